// file: core/kbd_io_decoder.sv
// Keyboard attachment channel instruction decoder
`timescale 1ns/1ps
`default_nettype none
module kbd_io_decoder
  import kbd_pkg::*;
(
  input wire logic clk_i,                 // 100 MHz clock
  input wire logic sys_rst_i,             // Synchronous reset, high
  input wire logic load_instruction_strobe_i,  // Load instruction selected
  input wire logic sense_instruction_strobe_i, // Sense instruction selected
  input wire logic start_instruction_strobe_i, // Start instruction selected
  input wire logic addr_cycle_i,          // Address-phase cycle
  input wire logic ctrl_cycle_i,          // Control-byte cycle
  input wire logic transfer_cycle_i,      // Transfer cycle
  input wire logic transfer_first_i,      // First transfer cycle
  input wire logic [3:0] phase_i,         // Channel clock phase number
  input wire logic [7:0] outbound_byte_bus_i, // Outbound byte
  input wire logic interrupt_poll_i,      // Channel interrupt poll
  input wire logic char_ready_i,          // Encoder character ready
  input wire logic shift_key_i,           // Shift key is the key down
  input wire logic [7:0] enc_status_i,    // Encoder status byte
  input wire logic [7:0] enc_data_i,      // Encoder key code
  output logic [7:0] inbound_byte_bus_o,  // Inbound byte
  output logic [1:0] cond_code_o,         // Condition code answer
  output logic [KBD_NUM_CMD-1:0] cmd_lamp_o, // Command lamps
  output logic [7:0] field_lamp_o,        // Field lamps
  output logic kbd_unlock_o,              // Keyboard unlocked
  output logic kbd_restore_o,             // Restore pulse
  output logic bit6_latch_o,              // Bit 6 controlled latch
  output logic int_enable_o,              // Interrupt enable latch
  output logic int_request_o,             // Pending request latch
  output logic int_polled_o               // Request shown during poll
);
  kbd_key_if key ();
  kbd_key_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .char_ready_i(char_ready_i),
    .status_i(enc_status_i),
    .data_i(enc_data_i),
    .key(key)
  );

  logic shift_s1_q;
  logic shift_s2_q;
  logic poll_s1_q;
  logic poll_s2_q;
  kbd_sel_t sel_q;
  kbd_sel_t sel_d;
  logic start_q;
  logic [1:0] load_n_q;
  logic [7:0] obr_q;
  logic load_first_q;
  logic [KBD_NUM_CMD-1:0] cmd_q;
  logic [7:0] field_q;
  logic unlock_q;
  logic restore_q;
  logic bit6_q;
  logic ena_q;
  logic req_q;
  logic interlock_q;
  logic key_seen_q;
  logic char_prev_q;
  logic [7:0] dbi_q;
  logic [1:0] cc_q;
  logic polled_q;

  always_ff @(posedge clk_i)
  begin
    shift_s1_q <= shift_key_i;
    shift_s2_q <= shift_s1_q;
    poll_s1_q <= interrupt_poll_i;
    poll_s2_q <= poll_s1_q;
  end

  // Address decode and strobes
  wire addr_hit = outbound_byte_bus_i[KBD_QA_HI:KBD_QA_LO] == KBD_DEV_ADDR;
  wire q_take = addr_cycle_i && phase_i == KBD_PH_SAMPLE && addr_hit;
  wire sel_clr = addr_cycle_i && phase_i == KBD_PH_CLR_SEL;
  wire take_load = q_take && load_instruction_strobe_i;
  wire take_sense = q_take && sense_instruction_strobe_i;
  wire take_start = q_take && start_instruction_strobe_i;
  wire xfer_sample = transfer_cycle_i && phase_i == KBD_PH_SAMPLE;
  wire load_byte = xfer_sample && sel_q == KBD_SEL_LOAD;
  wire active_byte = load_byte && transfer_first_i;
  wire field_load = active_byte && load_n_q[KBD_N_FIELD_BIT];
  wire [7:0] cmd_code = obr_q;
  wire cmd_valid = cmd_code >= 8'h01 && cmd_code <= 8'h08;
  wire [2:0] cmd_idx = 3'(cmd_code - 8'h01);
  wire ctrl_sample = ctrl_cycle_i && start_q && phase_i == KBD_PH_SAMPLE;
  wire ctrl_p4 = ctrl_cycle_i && start_q && phase_i == KBD_PH_CLR_LOCK;
  wire [7:0] cb = outbound_byte_bus_i;
  wire cb_restore = cb[KBD_CB_RST_A] && cb[KBD_CB_RST_B];
  wire cb_lock_any = cb[KBD_CB_RST_A] || cb[KBD_CB_RST_B];
  wire cb_set_req = cb[KBD_CB_REQ] && !cb[KBD_CB_CLRREQ];
  wire char_rise = key.any_char && !char_prev_q;
  wire key_event = char_rise && !shift_s2_q;
  wire req_set = key_event && interlock_q && ena_q;
  wire sense_xfer = xfer_sample && sel_q == KBD_SEL_SENSE;
  wire [7:0] stat_byte = key_seen_q ? key.status : KBD_IDLE_STATUS;
  wire [7:0] data_byte = key_seen_q ? key.data : KBD_IDLE_DATA;

  always_comb
  begin
    sel_d = sel_q;
    if (sel_clr)
      sel_d = KBD_SEL_NONE;
    if (take_load)
      sel_d = KBD_SEL_LOAD;
    else if (take_sense)
      sel_d = KBD_SEL_SENSE;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sel_q <= KBD_SEL_NONE;
      start_q <= 1'b0;
      load_n_q <= 2'h0;
      cc_q <= 2'h0;
    end
    else
    begin
      sel_q <= sel_d;
      if (sel_clr)
        start_q <= 1'b0;
      if (take_start)
        start_q <= 1'b1;
      if (take_load)
        load_n_q <= outbound_byte_bus_i[KBD_N_HI:KBD_N_LO];
      if (take_sense)
        cc_q <= KBD_CC_B;
      else if (take_load || take_start)
        cc_q <= KBD_CC_A;
      else if (sel_clr)
        cc_q <= 2'h0;
    end
  end

  // Outbound register takes both load bytes; only the first drives lamps
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      obr_q <= 8'h00;
    else if (load_byte)
      obr_q <= outbound_byte_bus_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      load_first_q <= 1'b0;
    else
      load_first_q <= active_byte;
  end

  wire lamp_go = load_first_q;
  wire [1:0] lamp_n = load_n_q;
  wire do_field = lamp_go && lamp_n[KBD_N_FIELD_BIT];
  wire do_cmd_on = lamp_go && lamp_n == KBD_N_CMD_ON && cmd_valid;
  wire do_cmd_off = lamp_go && lamp_n == KBD_N_CMD_OFF && cmd_valid;

  genvar gi;
  generate
    for (gi = 0; gi < KBD_NUM_CMD; gi++)
    begin : g_cmd
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          cmd_q[gi] <= 1'b0;
        else if (do_cmd_on && cmd_idx == 3'(gi))
          cmd_q[gi] <= 1'b1;
        else if (do_cmd_off && cmd_idx == 3'(gi))
          cmd_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      field_q <= 8'h00;
    else if (do_field)
      field_q <= obr_q;
  end

  // Start control byte decode
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      unlock_q <= 1'b0;
      restore_q <= 1'b0;
      bit6_q <= 1'b0;
      ena_q <= 1'b0;
      interlock_q <= 1'b0;
    end
    else
    begin
      restore_q <= ctrl_sample && cb_restore;
      if (ctrl_p4 && cb_lock_any)
        unlock_q <= 1'b0;
      if (ctrl_sample && cb_restore)
        unlock_q <= 1'b1;
      if (ctrl_sample)
        bit6_q <= cb[KBD_CB_B6];
      if (ctrl_sample)
        ena_q <= cb[KBD_CB_ENA];
      if (ctrl_sample && cb_restore)
        interlock_q <= 1'b1;
      else if (key_event)
        interlock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      req_q <= 1'b0;
      char_prev_q <= 1'b0;
      key_seen_q <= 1'b0;
    end
    else
    begin
      char_prev_q <= key.any_char;
      if (key_event)
        key_seen_q <= 1'b1;
      if (req_set || (ctrl_sample && cb_set_req))
        req_q <= 1'b1;
      else if (ctrl_sample && cb[KBD_CB_CLRREQ])
        req_q <= 1'b0;
    end
  end

  // Inbound assembler
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      dbi_q <= 8'h00;
      polled_q <= 1'b0;
    end
    else
    begin
      polled_q <= poll_s2_q && req_q;
      if (sense_xfer)
        dbi_q <= transfer_first_i ? stat_byte : data_byte;
      else if (poll_s2_q && req_q)
        dbi_q <= 8'h01;
      else
        dbi_q <= 8'h00;
    end
  end

  assign inbound_byte_bus_o = dbi_q;
  assign cond_code_o = cc_q;
  assign cmd_lamp_o = cmd_q;
  assign field_lamp_o = field_q;
  assign kbd_unlock_o = unlock_q;
  assign kbd_restore_o = restore_q;
  assign bit6_latch_o = bit6_q;
  assign int_enable_o = ena_q;
  assign int_request_o = req_q;
  assign int_polled_o = polled_q;

  // Assertions
  sel_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sel_clr && !take_load && !take_sense |=> sel_q == KBD_SEL_NONE)
    else $error("selection not cleared");
  sense_cc_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_sense |=> cc_q == KBD_CC_B)
    else $error("sense code not B");
  field_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    field_load |=> ##1 field_q == $past(obr_q, 1))
    else $error("field lamps wrong");
  bad_cmd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lamp_go && !lamp_n[KBD_N_FIELD_BIT] && !cmd_valid |=> $stable(cmd_q))
    else $error("command lamp changed on bad code");
  restore_both_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    restore_q |-> $past(ctrl_sample) && $past(cb_restore))
    else $error("restore without both bits");
  no_req_27_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_sample && cb[KBD_CB_REQ] && cb[KBD_CB_CLRREQ] && !req_set |=> !req_q)
    else $error("request set with bits 2 and 7");
  req_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_sample && cb[KBD_CB_CLRREQ] && !req_set |=> !req_q)
    else $error("request not cleared");
  req_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_set |=> req_q [*2])
    else $error("key did not raise request");
  poll_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    polled_q |-> $past(poll_s2_q) && $past(req_q))
    else $error("request shown outside poll");
  lock_p4_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_p4 && cb_lock_any |=> !unlock_q)
    else $error("lock not cleared at phase 4");
  idle_sense_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sense_xfer && transfer_first_i && !key_seen_q |=> dbi_q == KBD_IDLE_STATUS)
    else $error("idle status wrong");
  load_cc_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_load |=> cc_q == KBD_CC_A)
    else $error("load code not A");
  start_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_start |=> start_q)
    else $error("start latch not set");
  cmd_on_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    do_cmd_on |=> (cmd_q & (8'h01 << $past(cmd_idx))) != 8'h00)
    else $error("command lamp not lit");
  cmd_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    do_cmd_off |=> (cmd_q & (8'h01 << $past(cmd_idx))) == 8'h00)
    else $error("command lamp not cleared");
  second_byte_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    load_byte && !transfer_first_i |=> ##1 $stable(field_q) && $stable(cmd_q))
    else $error("second load byte changed a lamp");
  sense_status_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sense_xfer && transfer_first_i && key_seen_q |=> dbi_q == $past(key.status))
    else $error("status byte wrong");
  sense_data_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sense_xfer && !transfer_first_i && key_seen_q |=> dbi_q == $past(key.data))
    else $error("data byte wrong");
  bit6_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_sample && !cb[KBD_CB_B6] |=> !bit6_q)
    else $error("bit 6 latch not cleared");
  ena_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_sample && cb[KBD_CB_ENA] |=> ena_q)
    else $error("enable not set");
  unlock_restore_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_sample && cb_restore |=> unlock_q && interlock_q)
    else $error("restore did not unlock");
  start_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sel_clr && !take_start |=> !start_q)
    else $error("start latch not cleared");
  poll_show_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    poll_s2_q && req_q && !sense_xfer |=> polled_q && dbi_q == 8'h01)
    else $error("request not shown during poll");
  reset_clear_a: assert property (@(posedge clk_i)
    sys_rst_i |=> cmd_q == 8'h00 && field_q == 8'h00 && !ena_q && !req_q)
    else $error("latches not cleared by reset");
  cover_load: cover property (@(posedge clk_i) field_load);
  cover_sense: cover property (@(posedge clk_i) sense_xfer && !transfer_first_i);
  cover_restore: cover property (@(posedge clk_i) ctrl_sample && cb_restore);
  cover_poll: cover property (@(posedge clk_i) polled_q);
  cover_cmd: cover property (@(posedge clk_i) do_cmd_on);
endmodule : kbd_io_decoder
`default_nettype wire

// file: shared/kbd_pkg.sv
// Constants and types of the keyboard channel instruction decoder
// Overview of operation
// - Load: address cycle decodes address, answers condition code, sets load latch per N.
// - Load transfer: first outbound byte sets or clears command or field lamp latches.
// - Command load with undefined code is accepted and changes no command lamp.
// - Field load sets lamps with one bits, clears lamps with zero bits.
// - Second load byte is registered but affects no lamp.
// - Load, sense and start selection latches clear at phase 2 of next address cycle.
// - Command lamps hold until turned off; field lamps hold until next field load.
// - Sense: decode address, answer condition code B, set sense latch.
// - Sense drives status byte on first transfer, key code on the next.
// - Status byte is bit significant and tells the key type.
// - Start: decode address, answer code, set start latch, then decode control byte.
// - Keyboard restore only when control bits 4 and 5 are both set.
// - All control bytes accepted; bits 2 and 7 together do not set request.
// - Lock latch clears at phase 4 of control cycle when bit 4 or 5 set.
// - Bit 6 latch clears at phase 5 of control cycle when bit 6 decode inactive.
// - With interrupts enabled and the interlock set, any key except shift raises an interrupt request.
// - Character ready from the encoder is synchronised and used as any-character.
// - Request set by any-character with interlock and enable; shown only during poll.
// - Start with control bit 7 clears the request; otherwise it stays pending.
// - Sense before any key returns status 80 and data 00.
package kbd_pkg;
  localparam logic [3:0] KBD_DEV_ADDR = 4'h1;
  localparam int KBD_QA_HI = 7;
  localparam int KBD_QA_LO = 4;
  localparam int KBD_N_LO = 0;
  localparam int KBD_N_HI = 1;
  localparam logic [1:0] KBD_N_CMD_OFF = 2'h0;
  localparam logic [1:0] KBD_N_CMD_ON = 2'h1;
  localparam int KBD_N_FIELD_BIT = 1;
  localparam logic [3:0] KBD_PH_CLR_SEL = 4'h2;
  localparam logic [3:0] KBD_PH_CLR_LOCK = 4'h4;
  localparam logic [3:0] KBD_PH_SAMPLE = 4'h5;
  localparam int KBD_CB_REQ = 2;
  localparam int KBD_CB_ENA = 3;
  localparam int KBD_CB_RST_A = 4;
  localparam int KBD_CB_RST_B = 5;
  localparam int KBD_CB_B6 = 6;
  localparam int KBD_CB_CLRREQ = 7;
  localparam int KBD_NUM_CMD = 8;
  localparam logic [7:0] KBD_IDLE_STATUS = 8'h80;
  localparam logic [7:0] KBD_IDLE_DATA = 8'h00;
  localparam logic [1:0] KBD_CC_B = 2'h2;
  localparam logic [1:0] KBD_CC_A = 2'h1;
  typedef enum logic [2:0] {
    KBD_SEL_NONE = 3'h1,
    KBD_SEL_LOAD = 3'h2,
    KBD_SEL_SENSE = 3'h4
  } kbd_sel_t;
endpackage : kbd_pkg

// file: shared/kbd_key_if.sv
// Interface carrying synchronised encoder signals between modules
`timescale 1ns/1ps
`default_nettype none
interface kbd_key_if;
  logic any_char;
  logic [7:0] status;
  logic [7:0] data;
  modport src (output any_char, status, data);
  modport dst (input any_char, status, data);
endinterface : kbd_key_if
`default_nettype wire

// file: core/kbd_key_sync.sv
// Two-flop synchroniser for the encode board lines
`timescale 1ns/1ps
`default_nettype none
module kbd_key_sync
  import kbd_pkg::*;
(
  input wire logic clk_i,           // Clock
  input wire logic sys_rst_i,       // Synchronous reset
  input wire logic char_ready_i,    // Encoder character ready
  input wire logic [7:0] status_i,  // Encoder status byte
  input wire logic [7:0] data_i,    // Encoder key code
  kbd_key_if.src key                // Synchronised outputs
);
  logic [16:0] s1_q;
  logic [16:0] s2_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= 17'h0;
      s2_q <= 17'h0;
    end
    else
    begin
      s1_q <= {char_ready_i, status_i, data_i};
      s2_q <= s1_q;
    end
  end
  assign key.any_char = s2_q[16];
  assign key.status = s2_q[15:8];
  assign key.data = s2_q[7:0];
endmodule : kbd_key_sync
`default_nettype wire

// file: verif/kbd_chan_model.sv
// Processor channel model that issues keyboard instructions cycle by cycle
`timescale 1ns/1ps
`default_nettype none
module kbd_chan_model
  import kbd_pkg::*;
(
  input wire logic clk_i,         // Clock
  input wire logic [7:0] dbi_i,   // Inbound byte from the attachment
  input wire logic [1:0] cc_i,    // Condition code answer
  output logic [2:0] strobe_o,    // Load, sense, start strobes
  output logic [2:0] cyc_o,       // Address, control, transfer cycles
  output logic first_o,           // First transfer cycle
  output logic [3:0] phase_o,     // Channel phase number
  output logic [7:0] dbo_o        // Outbound byte
);
  logic [7:0] store_q [2];
  initial
  begin
    strobe_o = 3'h0;
    cyc_o = 3'h0;
    first_o = 1'b0;
    phase_o = 4'h0;
    dbo_o = 8'h5a;
  end
  // Eight phases; the answer to the phase 5 sample stands one cycle, read at phase 6
  task automatic cyc(input logic [2:0] c, input logic f, input logic [7:0] b,
                     output logic [7:0] r, output logic [1:0] cc);
    for (int p = 0; p < 8; p++)
    begin
      @(negedge clk_i);
      phase_o = p[3:0];
      cyc_o = c;
      first_o = f;
      dbo_o = b;
      if (p == 6)
      begin
        r = dbi_i;
        cc = cc_i;
      end
    end
  endtask : cyc
  task automatic instr(input int k, input logic [7:0] q, input logic [7:0] b1,
                       input logic [7:0] b2, output logic [7:0] st, output logic [7:0] dt,
                       output logic [1:0] cc);
    logic [7:0] r;
    logic [1:0] c2;
    @(negedge clk_i);
    strobe_o = 3'h1 << k;
    cyc(3'h1, 1'b0, q, r, cc);
    if (k == 2)
      cyc(3'h2, 1'b0, b1, r, c2);
    else
    begin
      cyc(3'h4, 1'b1, b1, store_q[0], c2);
      cyc(3'h4, 1'b0, b2, store_q[1], c2);
    end
    st = store_q[0];
    dt = store_q[1];
    @(negedge clk_i);
    strobe_o = 3'h0;
    cyc_o = 3'h0;
    first_o = 1'b0;
    dbo_o = ~dbo_o;
  endtask : instr
endmodule : kbd_chan_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking testbench of the keyboard instruction decoder
`timescale 1ns/1ps
`default_nettype none
`define KBD_CHK(nm, ex, gt) \
  begin tests_run++; if ((ex) !== (gt)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module tb_top
  import kbd_pkg::*;
;
  localparam logic [7:0] QA = {KBD_DEV_ADDR, 4'h0};
  localparam logic [7:0] ENA = 8'h1 << KBD_CB_ENA;
  localparam logic [7:0] RST = (8'h1 << KBD_CB_RST_A) | (8'h1 << KBD_CB_RST_B);
  logic clk_i, sys_rst_i, first, poll, char_rdy, shift, unlock, restore, b6, ena, req;
  logic polled;
  logic [2:0] strobe, cyc;
  logic [3:0] phase;
  logic [7:0] outbound_byte_bus, es, ed, inbound_byte_bus, cmd, fld, st, dt;
  logic [1:0] cc;
  logic [1:0] ccr;
  int fail_count = 0;
  int tests_run = 0;
  int n_rst = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (restore === 1'b1) n_rst++;
  kbd_io_decoder u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .load_instruction_strobe_i(strobe[0]), .sense_instruction_strobe_i(strobe[1]),
    .start_instruction_strobe_i(strobe[2]), .addr_cycle_i(cyc[0]), .ctrl_cycle_i(cyc[1]),
    .transfer_cycle_i(cyc[2]), .transfer_first_i(first), .phase_i(phase),
    .outbound_byte_bus_i(outbound_byte_bus), .interrupt_poll_i(poll), .char_ready_i(char_rdy),
    .shift_key_i(shift), .enc_status_i(es), .enc_data_i(ed), .inbound_byte_bus_o(inbound_byte_bus),
    .cond_code_o(cc), .cmd_lamp_o(cmd), .field_lamp_o(fld), .kbd_unlock_o(unlock),
    .kbd_restore_o(restore), .bit6_latch_o(b6), .int_enable_o(ena),
    .int_request_o(req), .int_polled_o(polled));
  kbd_chan_model u_chan (.clk_i(clk_i), .dbi_i(inbound_byte_bus), .cc_i(cc), .strobe_o(strobe),
    .cyc_o(cyc), .first_o(first), .phase_o(phase), .dbo_o(outbound_byte_bus));
  task automatic start(input logic [7:0] cb);
    u_chan.instr(2, QA, cb, 8'h00, st, dt, ccr);
    `KBD_CHK("start code", KBD_CC_A, ccr)
  endtask : start
  task automatic load(input logic [7:0] q, input logic [7:0] b1, input logic [7:0] b2);
    u_chan.instr(0, q, b1, b2, st, dt, ccr);
  endtask : load
  task automatic key(input logic sh);
    @(negedge clk_i);
    shift = sh;
    char_rdy = 1'b1;
    repeat (8) @(negedge clk_i);
    char_rdy = 1'b0;
    shift = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : key
  task automatic t_reset();
    `KBD_CHK("lamps", 16'h0, {cmd, fld})
    `KBD_CHK("enable request", 2'h0, {ena, req})
    u_chan.instr(1, QA, 8'h00, 8'h00, st, dt, ccr);
    `KBD_CHK("sense code", KBD_CC_B, ccr)
    `KBD_CHK("idle status", KBD_IDLE_STATUS, st)
    `KBD_CHK("idle data", KBD_IDLE_DATA, dt)
  endtask : t_reset
  task automatic t_lamps();
    load(QA | KBD_N_CMD_ON, 8'h03, 8'h07);
    `KBD_CHK("load code", KBD_CC_A, ccr)
    `KBD_CHK("cmd on", 8'h04, cmd)
    load(QA | KBD_N_CMD_ON, 8'h09, 8'h01);
    `KBD_CHK("cmd bad code", 8'h04, cmd)
    load(QA | KBD_N_CMD_OFF, 8'h00, 8'h03);
    `KBD_CHK("cmd zero code", 8'h04, cmd)
    load(QA | (4'h1 << KBD_N_FIELD_BIT), 8'ha5, 8'hff);
    `KBD_CHK("field set", 8'ha5, fld)
    `KBD_CHK("cmd held", 8'h04, cmd)
    load(QA | (4'h1 << KBD_N_FIELD_BIT), 8'hff, 8'h00);
    `KBD_CHK("field all", 8'hff, fld)
    load(QA | KBD_N_CMD_OFF, 8'h03, 8'h00);
    `KBD_CHK("cmd off", 8'h00, cmd)
    `KBD_CHK("field held", 8'hff, fld)
    load(8'h20 | KBD_N_CMD_ON, 8'h01, 8'h01);
    `KBD_CHK("other address", 10'h0, {cc, cmd})
    load(QA | (4'h1 << KBD_N_FIELD_BIT), 8'h00, 8'h00);
    `KBD_CHK("field clear", 8'h00, fld)
  endtask : t_lamps
  task automatic t_start();
    int n0;
    n0 = n_rst;
    start(8'h1 << KBD_CB_RST_A);
    `KBD_CHK("half restore", n0, n_rst)
    start(ENA | RST | (8'h1 << KBD_CB_B6));
    `KBD_CHK("restore pulse", n0 + 1, n_rst)
    `KBD_CHK("enable unlock b6", 3'h7, {ena, unlock, b6})
    start(ENA);
    `KBD_CHK("bit6 clear", 2'h2, {ena, b6})
    start(ENA | (8'h1 << KBD_CB_REQ));
    `KBD_CHK("request by bit2", 1'b1, req)
    start(ENA | (8'h1 << KBD_CB_REQ) | (8'h1 << KBD_CB_CLRREQ));
    `KBD_CHK("bits 2 and 7", 1'b0, req)
    start(8'h00);
    `KBD_CHK("disable", 1'b0, ena)
  endtask : t_start
  task automatic t_key();
    start(ENA | RST);
    key(1'b1);
    `KBD_CHK("shift key", 1'b0, req)
    start(ENA | RST);
    key(1'b0);
    `KBD_CHK("key request", 1'b1, req)
    `KBD_CHK("no poll", 1'b0, polled)
    @(negedge clk_i);
    poll = 1'b1;
    repeat (5) @(negedge clk_i);
    `KBD_CHK("polled", 1'b1, polled)
    `KBD_CHK("poll bit", 8'h01, inbound_byte_bus)
    poll = 1'b0;
    repeat (5) @(negedge clk_i);
    `KBD_CHK("poll gone", 2'h1, {polled, req})
    u_chan.instr(1, QA, 8'h00, 8'h00, st, dt, ccr);
    `KBD_CHK("key status", es, st)
    `KBD_CHK("key data", ed, dt)
    start(ENA | RST | (8'h1 << KBD_CB_CLRREQ));
    `KBD_CHK("request cleared", 1'b0, req)
  endtask : t_key
  task automatic t_midreset();
    load(QA | (4'h1 << KBD_N_FIELD_BIT), 8'h3c, 8'h00);
    start(ENA | (8'h1 << KBD_CB_REQ));
    `KBD_CHK("before reset", 10'h33c, {ena, req, fld})
    sys_rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
  endtask : t_midreset
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    poll = 1'b0;
    char_rdy = 1'b0;
    shift = 1'b0;
    es = 8'h41;
    ed = 8'h2c;
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
    t_lamps();
    t_start();
    t_key();
    t_midreset();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
